// ### src/plc_link_regs.sv
// Physical-layer link configuration register bank with retrain and PRBS seed control
// Behaviour
// RULE1 - Compat bit 8 selects gen1 mode, resets zero
// RULE2 - Compat mode clears undefined training set bits
// RULE3 - Bit 11 disables crosslink training, resets zero
// RULE4 - Speed bit zero: upgrade after first L0
// RULE5 - Speed bit one: no automatic speed change
// RULE6 - Speed bit reset: downstream zero, others one
// RULE7 - Writing one to bit 31 forces Detect
// RULE8 - Retrain bit always reads zero
// RULE9 - Write completes before retrain action begins
// RULE10 - Upstream port retrain waits one millisecond
// RULE11 - Sixteen-bit seed, resets ones, drives PRBS
// RULE12 - Seed change reloads PRBS counter
// RULE13 - Writing zero to retrain does nothing
module plc_link_regs #(
  parameter int RETRAIN_DELAY_CYC = plc_pkg::RETRAIN_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire plc_pkg::plc_mode_t port_mode,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic first_l0_from_detect,
  input wire logic gen2_permitted,
  input wire logic crosslink_active,
  input wire logic [7:0] ts_bits_in,
  output logic [7:0] ts_bits_out,
  output logic speed_change_req,
  output plc_pkg::plc_phy_ctl_t phy_ctl,
  output logic [15:0] prbs_state
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic compat_q;
  logic xlink_dis_q;
  logic speed_ctl_q;
  logic [15:0] seed_q;
  logic [31:0] rdata_q;
  logic reset_seen_q;
  logic wr_cfg;
  logic wr_retrain;
  logic wr_seed;
  logic seed_changed;

  // Address decode shared by write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction : hit

  assign wr_cfg = wr && hit(addr, plc_pkg::ADDR_CFG);
  assign wr_retrain = wr && hit(addr, plc_pkg::ADDR_RETRAIN);
  assign wr_seed = wr && hit(addr, plc_pkg::ADDR_SEED);

  // Config bits; the speed bit reset value is strapped by the port mode,
  // so it is loaded by a clocked process during reset rather than async
  always_ff @(posedge clk) begin
    if (rst) begin
      compat_q <= plc_pkg::COMPAT_RST; // RULE1
      xlink_dis_q <= plc_pkg::XLINK_DIS_RST; // RULE3
      speed_ctl_q <= (port_mode == plc_pkg::PLC_MODE_DOWNSTREAM) ?
                     plc_pkg::SPEED_CTL_RST_DS : plc_pkg::SPEED_CTL_RST_OTHER; // RULE6
    end else if (wr_cfg) begin
      compat_q <= wdata[plc_pkg::BIT_COMPAT]; // RULE1
      xlink_dis_q <= wdata[plc_pkg::BIT_XLINK_DIS]; // RULE3
      speed_ctl_q <= wdata[plc_pkg::BIT_SPEED_CTL]; // RULE4 RULE5
    end
  end

  // Seed register; only a real change of value reloads the generator
  assign seed_changed = wr_seed && (wdata[15:0] != seed_q);
  always_ff @(posedge clk) begin
    if (rst) begin
      seed_q <= plc_pkg::SEED_RST; // RULE11
    end else if (wr_seed) begin
      seed_q <= wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data registered, valid the cycle after rd; unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (rd) begin
      rdata_q <= '0;
      if (hit(addr, plc_pkg::ADDR_CFG)) begin
        rdata_q[plc_pkg::BIT_COMPAT] <= compat_q;
        rdata_q[plc_pkg::BIT_XLINK_DIS] <= xlink_dis_q;
        rdata_q[plc_pkg::BIT_SPEED_CTL] <= speed_ctl_q;
      end else if (hit(addr, plc_pkg::ADDR_SEED)) begin
        rdata_q[15:0] <= seed_q;
      end
      // Retrain register always reads all zero
    end else begin
      rdata_q <= '0;
    end
  end
  assign rdata = rdata_q; // RULE8

  // ----------------------------------------------------------------
  // Full retrain sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLC_RT_IDLE,
    PLC_RT_ACK,
    PLC_RT_WAIT,
    PLC_RT_FIRE
  } plc_rt_state_t;
  plc_rt_state_t rt_q;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  logic retrain_req;

  // Only a one in bit 31 counts as a request
  assign retrain_req = wr_retrain && wdata[plc_pkg::BIT_RETRAIN]; // RULE13

  // The write is acknowledged in its own cycle (no wait states), so the
  // earliest action is two cycles later; upstream adds the 1 ms wait
  always_ff @(posedge clk) begin
    if (rst) begin
      rt_q <= PLC_RT_IDLE;
    end else begin
      case (rt_q)
        PLC_RT_IDLE: begin
          if (retrain_req) begin
            rt_q <= PLC_RT_ACK; // RULE9
          end
        end
        PLC_RT_ACK: begin
          rt_q <= (port_mode == plc_pkg::PLC_MODE_UPSTREAM) ? PLC_RT_WAIT : PLC_RT_FIRE; // RULE10
        end
        PLC_RT_WAIT: begin
          if (timer_done) begin
            rt_q <= PLC_RT_FIRE; // RULE10
          end
        end
        PLC_RT_FIRE: begin
          rt_q <= retrain_req ? PLC_RT_ACK : PLC_RT_IDLE;
        end
        default: begin
          rt_q <= PLC_RT_IDLE;
        end
      endcase
    end
  end

  assign timer_start = (rt_q == PLC_RT_ACK) && (port_mode == plc_pkg::PLC_MODE_UPSTREAM);

  plc_retrain_timer #(
    .DELAY_CYC(RETRAIN_DELAY_CYC)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .start(timer_start),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ----------------------------------------------------------------
  // Speed change request
  // ----------------------------------------------------------------
  // One-shot after the first L0 entry since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_seen_q <= 1'b0;
    end else if (first_l0_from_detect) begin
      reset_seen_q <= 1'b1;
    end
  end

  logic speed_req_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_req_q <= 1'b0;
    end else begin
      speed_req_q <= first_l0_from_detect && !reset_seen_q && !speed_ctl_q && gen2_permitted; // RULE4 RULE5
    end
  end
  assign speed_change_req = speed_req_q;

  // ----------------------------------------------------------------
  // Physical layer controls
  // ----------------------------------------------------------------
  logic [7:0] ts_q;
  // Only the low two bits are defined at first generation; the rest masked
  always_ff @(posedge clk) begin
    if (rst) begin
      ts_q <= '0;
    end else begin
      ts_q <= compat_q ? (ts_bits_in & 8'h03) : ts_bits_in; // RULE2
    end
  end
  assign ts_bits_out = ts_q;

  assign phy_ctl.compat_gen1 = compat_q; // RULE1
  assign phy_ctl.crosslink_disable = xlink_dis_q; // RULE3
  assign phy_ctl.auto_speed_up = !speed_ctl_q; // RULE4 RULE5
  assign phy_ctl.force_detect = (rt_q == PLC_RT_FIRE); // RULE7

  // ----------------------------------------------------------------
  // PRBS generator
  // ----------------------------------------------------------------
  plc_prbs_gen u_prbs (
    .clk(clk),
    .rst(rst),
    .load(seed_changed), // RULE12
    .seed(wdata[15:0]),
    .run(crosslink_active && !xlink_dis_q), // RULE11
    .state(prbs_state)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_retrain_reads_zero;
    @(posedge clk) disable iff (rst)
      (rd && hit(addr, plc_pkg::ADDR_RETRAIN)) |=> (rdata == 32'h0000_0000);
  endproperty
  a_retrain_reads_zero: assert property (p_retrain_reads_zero) else $error("Retrain read not zero"); // RULE8

  // The write cycle and the cycle after it must stay free of detect
  property p_no_same_cycle_detect;
    @(posedge clk) disable iff (rst)
      (retrain_req && rt_q == PLC_RT_IDLE) |-> !phy_ctl.force_detect ##1 !phy_ctl.force_detect;
  endproperty
  a_no_same_cycle_detect: assert property (p_no_same_cycle_detect) else $error("Detect in write cycle"); // RULE9

  property p_ds_detect_two;
    @(posedge clk) disable iff (rst)
      (retrain_req && rt_q == PLC_RT_IDLE && port_mode != plc_pkg::PLC_MODE_UPSTREAM)
        |-> ##2 phy_ctl.force_detect;
  endproperty
  a_ds_detect_two: assert property (p_ds_detect_two) else $error("Retrain not applied"); // RULE7

  property p_up_wait;
    @(posedge clk) disable iff (rst)
      (rt_q == PLC_RT_ACK && port_mode == plc_pkg::PLC_MODE_UPSTREAM) |=> !phy_ctl.force_detect [*8];
  endproperty
  a_up_wait: assert property (p_up_wait) else $error("Upstream retrain too early"); // RULE10

  property p_zero_write_idle;
    @(posedge clk) disable iff (rst)
      (wr_retrain && !wdata[plc_pkg::BIT_RETRAIN] && rt_q == PLC_RT_IDLE) |=> (rt_q == PLC_RT_IDLE);
  endproperty
  a_zero_write_idle: assert property (p_zero_write_idle) else $error("Zero write started retrain"); // RULE13

  property p_compat_mask;
    @(posedge clk) disable iff (rst)
      (compat_q && $stable(compat_q)) |=> (ts_bits_out[7:2] == 6'h00);
  endproperty
  a_compat_mask: assert property (p_compat_mask) else $error("Undefined TS bit set"); // RULE2

  property p_no_speed_when_held;
    @(posedge clk) disable iff (rst)
      speed_ctl_q && $past(speed_ctl_q) |-> !speed_change_req;
  endproperty
  a_no_speed_when_held: assert property (p_no_speed_when_held) else $error("Speed change while held"); // RULE5

  property p_speed_up;
    @(posedge clk) disable iff (rst)
      (first_l0_from_detect && !reset_seen_q && !speed_ctl_q && gen2_permitted) |=> speed_change_req;
  endproperty
  a_speed_up: assert property (p_speed_up) else $error("Speed change missing"); // RULE4

  property p_seed_reload;
    @(posedge clk) disable iff (rst)
      seed_changed |=> (prbs_state == seed_q);
  endproperty
  a_seed_reload: assert property (p_seed_reload) else $error("PRBS not reloaded"); // RULE12

  property p_cfg_readback;
    @(posedge clk) disable iff (rst)
      (rd && hit(addr, plc_pkg::ADDR_CFG)) |=>
        (rdata[plc_pkg::BIT_COMPAT] == $past(compat_q)) && (rdata[plc_pkg::BIT_XLINK_DIS] == $past(xlink_dis_q));
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) else $error("Config readback wrong"); // RULE1 RULE3

  // Speed bit reads back what is stored, whatever the strap gave it
  property p_speed_readback;
    @(posedge clk) disable iff (rst)
      (rd && hit(addr, plc_pkg::ADDR_CFG)) |=> (rdata[plc_pkg::BIT_SPEED_CTL] == $past(speed_ctl_q));
  endproperty
  a_speed_readback: assert property (p_speed_readback) else $error("Speed bit readback wrong"); // RULE4 RULE5

  // Seed reads back in the low half word only
  property p_seed_readback;
    @(posedge clk) disable iff (rst)
      (rd && hit(addr, plc_pkg::ADDR_SEED)) |=> (rdata == {16'h0000, $past(seed_q)});
  endproperty
  a_seed_readback: assert property (p_seed_readback) else $error("Seed readback wrong"); // RULE11

  // No register drives the upper half word, so bit 31 can never read one
  property p_upper_zero;
    @(posedge clk) disable iff (rst)
      rd |=> (rdata[31:16] == 16'h0000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Upper read bits not zero"); // RULE8

  // A request seen in idle is taken at once and never lost
  property p_ack_after_write;
    @(posedge clk) disable iff (rst)
      (retrain_req && rt_q == PLC_RT_IDLE) |=> (rt_q == PLC_RT_ACK);
  endproperty
  a_ack_after_write: assert property (p_ack_after_write) else $error("Retrain request lost"); // RULE9

  // Detect is a one-cycle command; a level would hold the link in reset
  property p_fire_one_cycle;
    @(posedge clk) disable iff (rst)
      phy_ctl.force_detect |=> !phy_ctl.force_detect;
  endproperty
  a_fire_one_cycle: assert property (p_fire_one_cycle) else $error("Detect longer than one cycle"); // RULE7

  // The delay counter runs exactly while the sequencer waits
  property p_timer_in_wait;
    @(posedge clk) disable iff (rst)
      timer_busy == (rt_q == PLC_RT_WAIT);
  endproperty
  a_timer_in_wait: assert property (p_timer_in_wait) else $error("Delay counter out of step"); // RULE10

  // Only the first L0 entry after reset may ask for a speed change
  property p_speed_once;
    @(posedge clk) disable iff (rst)
      reset_seen_q |=> !speed_change_req;
  endproperty
  a_speed_once: assert property (p_speed_once) else $error("Second speed change request"); // RULE4

  // Crosslink disabled: the pattern must not advance except on reload
  property p_xlink_hold;
    @(posedge clk) disable iff (rst)
      (xlink_dis_q && !seed_changed) |=> $stable(prbs_state);
  endproperty
  a_xlink_hold: assert property (p_xlink_hold) else $error("PRBS stepped while disabled"); // RULE3

  // Outside crosslink the pattern is frozen, so a reload stays visible
  property p_prbs_idle_hold;
    @(posedge clk) disable iff (rst)
      (!crosslink_active && !seed_changed) |=> $stable(prbs_state);
  endproperty
  a_prbs_idle_hold: assert property (p_prbs_idle_hold) else $error("PRBS stepped outside crosslink"); // RULE11

endmodule : plc_link_regs

// ### src/plc_pkg.sv
// Package: register map, field positions, reset values and timing for the link config block
package plc_pkg;
  localparam logic [11:0] ADDR_CFG = 12'h530;
  localparam logic [11:0] ADDR_RETRAIN = 12'h540;
  localparam logic [11:0] ADDR_SEED = 12'h55c;
  localparam int BIT_COMPAT = 8;
  localparam int BIT_XLINK_DIS = 11;
  localparam int BIT_SPEED_CTL = 14;
  localparam int BIT_RETRAIN = 31;
  localparam int SEED_W = 16;
  localparam logic [15:0] SEED_RST = 16'hffff;
  localparam logic COMPAT_RST = 1'b0;
  localparam logic XLINK_DIS_RST = 1'b0;
  localparam logic SPEED_CTL_RST_DS = 1'b0;
  localparam logic SPEED_CTL_RST_OTHER = 1'b1;
  // Retrain delay on an upstream port
  localparam int CLK_MHZ = 50;
  localparam int RETRAIN_DELAY_US = 1000;
  localparam int RETRAIN_DELAY_CYC = RETRAIN_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // Port operating modes
  typedef enum logic [1:0] {
    PLC_MODE_DOWNSTREAM,
    PLC_MODE_UPSTREAM,
    PLC_MODE_OTHER
  } plc_mode_t;
  // Control bundle driven into the physical layer
  typedef struct packed {
    logic compat_gen1;
    logic crosslink_disable;
    logic auto_speed_up;
    logic force_detect;
  } plc_phy_ctl_t;
endpackage : plc_pkg

// ### src/plc_retrain_timer.sv
// Delay counter that postpones a retrain request by a programmable cycle count
module plc_retrain_timer #(
  parameter int DELAY_CYC = plc_pkg::RETRAIN_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = plc_pkg::CNT_W;
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
  logic [plc_pkg::CNT_W-1:0] cnt_q;
  logic busy_q;
  // A new start while busy restarts the wait from zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= '0;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == LAST) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  assign busy = busy_q;
  assign done = busy_q && !start && (cnt_q == LAST);
endmodule : plc_retrain_timer

// ### src/plc_prbs_gen.sv
// PRBS generator, reloaded from the seed on demand
module plc_prbs_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] seed,
  input wire logic run,
  output logic [15:0] state
);
  logic [15:0] lfsr_q;
  // x^16+x^5+x^4+x^3+1 style feedback; reload takes precedence over stepping
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_q <= plc_pkg::SEED_RST;
    end else if (load) begin
      lfsr_q <= seed;
    end else if (run) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[4] ^ lfsr_q[3] ^ lfsr_q[2]};
    end
  end
  assign state = lfsr_q;
endmodule : plc_prbs_gen

// ### bench/plc_link_regs_tb_top.sv
// Self-checking testbench for the link configuration register bank
module plc_link_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals and stimulus table
  // ----------------------------------------
  // Short retrain delay keeps the upstream case fast
  localparam int DLY = 20;
  typedef struct {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } plc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  plc_pkg::plc_mode_t port_mode = plc_pkg::PLC_MODE_OTHER;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic first_l0_from_detect = 1'b0;
  logic gen2_permitted = 1'b1;
  logic crosslink_active = 1'b0;
  logic [7:0] ts_bits_in = 8'hff;
  logic [7:0] ts_bits_out;
  logic speed_change_req;
  plc_pkg::plc_phy_ctl_t phy_ctl;
  logic [15:0] prbs_state;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] got;
  // Reserved bits set on purpose, so masking is exercised; 0x600 is unmapped
  plc_row_t rows [5] = '{
    '{plc_pkg::ADDR_CFG, 32'hffffffff, 32'h00004900},
    '{plc_pkg::ADDR_RETRAIN, 32'h7fffffff, 32'h00000000},
    '{plc_pkg::ADDR_SEED, 32'hdeadbeef, 32'h0000beef},
    '{12'h600, 32'hffffffff, 32'h00000000},
    '{plc_pkg::ADDR_CFG, 32'h00000000, 32'h00000000}};

  // 50 MHz clock
  always #10 clk = ~clk;

  plc_link_regs #(.RETRAIN_DELAY_CYC(DLY)) DUT (
    .clk(clk),
    .rst(rst),
    .port_mode(port_mode),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .first_l0_from_detect(first_l0_from_detect),
    .gen2_permitted(gen2_permitted),
    .crosslink_active(crosslink_active),
    .ts_bits_in(ts_bits_in),
    .ts_bits_out(ts_bits_out),
    .speed_change_req(speed_change_req),
    .phy_ctl(phy_ctl),
    .prbs_state(prbs_state)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Prints the counts and the verdict, then stops
  task automatic test_done;
    $display("Counts: %0d compares, %0d errors", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Mode is sampled while reset is high, so it changes only here
  task automatic do_reset(input plc_pkg::plc_mode_t m);
    @(posedge clk);
    rst <= 1'b1;
    port_mode <= m;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rd_chk

  // Counts edges after the one that takes the write until detect shows
  task automatic retrain_wait(input int exp);
    bus_wr(plc_pkg::ADDR_RETRAIN, 32'h80000000);
    for (n = 1; n <= DLY + 10; n++) begin
      @(posedge clk);
      #1;
      if (phy_ctl.force_detect === 1'b1) break;
    end
    chk("retrain delay", exp, n);
    if (n > DLY + 10) test_done();
    @(posedge clk);
    #1;
    chk("detect pulse width", 32'h0, {31'h0, phy_ctl.force_detect});
  endtask : retrain_wait

  // Counts speed requests in the three cycles after an L0 entry
  task automatic l0_pulse(input logic [31:0] exp);
    @(posedge clk);
    first_l0_from_detect <= 1'b1;
    @(posedge clk);
    first_l0_from_detect <= 1'b0;
    got = 32'h0;
    repeat (3) begin
      #1;
      got = got + {31'h0, speed_change_req};
      @(posedge clk);
    end
    chk("speed requests", exp, got);
  endtask : l0_pulse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset(plc_pkg::PLC_MODE_OTHER);
    rd_chk("cfg reset", plc_pkg::ADDR_CFG, 32'h00004000);
    chk("auto speed", 32'h0, {31'h0, phy_ctl.auto_speed_up});
    rd_chk("retrain reset", plc_pkg::ADDR_RETRAIN, 32'h0);
    rd_chk("seed reset", plc_pkg::ADDR_SEED, 32'h0000ffff);
    chk("prbs reset", 32'h0000ffff, {16'h0, prbs_state});
    $display("Test reset done");
    for (int i = 0; i < 5; i++) begin
      bus_wr(rows[i].a, rows[i].w);
      // A wrongly started retrain would show detect in this cycle
      @(posedge clk);
      #1;
      chk("no detect", 32'h0, {31'h0, phy_ctl.force_detect});
      rd_chk("readback", rows[i].a, rows[i].e);
    end
    $display("Test table done");
    // Compat masks upper training set bits
    bus_wr(plc_pkg::ADDR_CFG, 32'h00000100);
    repeat (2) @(posedge clk);
    #1;
    chk("compat ctl", 32'h2, {30'h0, phy_ctl.compat_gen1, phy_ctl.crosslink_disable});
    chk("compat ts", 32'h03, {24'h0, ts_bits_out});
    bus_wr(plc_pkg::ADDR_CFG, 32'h00000800);
    repeat (2) @(posedge clk);
    #1;
    chk("xlink ctl", 32'h1, {30'h0, phy_ctl.compat_gen1, phy_ctl.crosslink_disable});
    chk("plain ts", 32'hff, {24'h0, ts_bits_out});
    $display("Test compat done");
    // Crosslink disabled: the seed loads but must not step
    bus_wr(plc_pkg::ADDR_SEED, 32'h00001234);
    #1;
    chk("seed load", 32'h1234, {16'h0, prbs_state});
    @(posedge clk);
    crosslink_active <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("prbs held", 32'h1234, {16'h0, prbs_state});
    bus_wr(plc_pkg::ADDR_CFG, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    chk("prbs steps", 32'h1, {31'h0, prbs_state !== 16'h1234});
    @(posedge clk);
    crosslink_active <= 1'b0;
    $display("Test seed done");
    do_reset(plc_pkg::PLC_MODE_DOWNSTREAM);
    rd_chk("cfg downstream", plc_pkg::ADDR_CFG, 32'h0);
    chk("auto speed", 32'h1, {31'h0, phy_ctl.auto_speed_up});
    l0_pulse(32'h1);
    l0_pulse(32'h0);
    do_reset(plc_pkg::PLC_MODE_OTHER);
    l0_pulse(32'h0);
    // Gen2 not permitted: even a downstream port must stay put
    gen2_permitted <= 1'b0;
    do_reset(plc_pkg::PLC_MODE_DOWNSTREAM);
    l0_pulse(32'h0);
    gen2_permitted <= 1'b1;
    $display("Test speed done");
    do_reset(plc_pkg::PLC_MODE_DOWNSTREAM);
    retrain_wait(1);
    rd_chk("retrain read", plc_pkg::ADDR_RETRAIN, 32'h0);
    do_reset(plc_pkg::PLC_MODE_UPSTREAM);
    retrain_wait(1 + DLY);
    $display("Test retrain done");
    test_done();
  end
endmodule : plc_link_regs_tb_top
